// [rtl/smic_counter.sv]
`timescale 1ns/100ps
`include "smic_defines.svh"
// Behaviour
// - in mode 0 the output drops when the mode is written and counting runs only while gate is high.
// - in mode 0 the output rises at terminal count and stays high until a new mode is written.
// - in mode 1 the output drops on the count tick after a gate rising edge and rises at terminal count.
// - in mode 2 the output goes low for exactly one tick per cycle and is high otherwise.
// - in mode 2 low pulses are spaced by the loaded count, reloading automatically.
// - in mode 3 the output is a square wave, high for half the count and low for the other half.
// - in mode 4 the output starts high and counting runs only while gate is high.
// - in mode 4 at terminal count the output goes low for one tick and then returns high.
// - mode 5 acts like mode 4 but counting starts on a gate rising edge.
module smic_counter #(
  parameter int CNT_W = `SMIC_CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cntTick,
  input wire logic gateIn,
  input wire smic_pkg::smic_cmd_t cmd,
  output logic outPin,
  output logic terminalCount
);
  import smic_pkg::*;

  // ************************************
  // state
  // ************************************
  smic_mode_t mode_ff;
  logic [CNT_W-1:0] load_ff, cnt_ff;
  logic armed_ff, running_ff, gate_ff, trig_ff, out_ff, tc_ff;
  logic gateRise, cntEn, atOne;

  assign gateRise = gateIn & ~gate_ff;
  assign atOne = (cnt_ff == CNT_W'(1));
  always_comb begin
    cntEn = 1'b0;
    case (mode_ff)
      SMIC_M0_TERM_INT, SMIC_M4_SW_STROBE: cntEn = running_ff & gateIn;
      SMIC_M2_RATE, SMIC_M3_SQUARE: cntEn = running_ff;
      SMIC_M1_ONESHOT, SMIC_M5_HW_STROBE: cntEn = running_ff & trig_ff;
      default: cntEn = 1'b0;
    endcase
  end

  // ************************************
  // gate edge capture
  // ************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gate_ff <= 1'b0;
    end else begin
      gate_ff <= gateIn;
    end
  end

  // pending trigger for edge-started modes, served at the next tick
  always_ff @(posedge clk) begin
    if (!resetn || cmd.modeWr) begin
      trig_ff <= 1'b0;
    end else if (gateRise && armed_ff) begin
      trig_ff <= 1'b1;
    end else if (cntTick && cntEn && atOne) begin
      trig_ff <= 1'b0;
    end
  end

  // ************************************
  // mode and load
  // ************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_ff <= smic_mode_t'(`SMIC_MODE_RST);
      load_ff <= CNT_W'(`SMIC_CNT_RST);
      armed_ff <= 1'b0;
    end else begin
      if (cmd.modeWr) begin
        mode_ff <= cmd.mode;
        armed_ff <= 1'b0;
      end
      if (cmd.countWr && !cmd.modeWr) begin
        load_ff <= cmd.count[CNT_W-1:0];
        armed_ff <= 1'b1;
      end
    end
  end

  // ************************************
  // down counter
  // ************************************
  always_ff @(posedge clk) begin
    if (!resetn || cmd.modeWr) begin
      cnt_ff <= CNT_W'(`SMIC_CNT_RST);
      running_ff <= 1'b0;
    end else if (cmd.countWr) begin
      cnt_ff <= cmd.count[CNT_W-1:0];
      running_ff <= 1'b1;
    end else if (running_ff && trig_ff && gateRise && (mode_ff == SMIC_M1_ONESHOT ||
                 mode_ff == SMIC_M5_HW_STROBE)) begin
      // gate edge mid-count restarts the shot from the loaded value
      cnt_ff <= load_ff;
    end else if (cntTick && cntEn) begin
      if (mode_ff == SMIC_M3_SQUARE) begin
        // two per tick, reload at the half point
        if (cnt_ff <= CNT_W'(2)) begin
          cnt_ff <= load_ff;
        end else begin
          cnt_ff <= cnt_ff - CNT_W'(2);
        end
      end else if (atOne) begin
        case (mode_ff)
          SMIC_M2_RATE: cnt_ff <= load_ff;
          SMIC_M1_ONESHOT, SMIC_M5_HW_STROBE: cnt_ff <= load_ff;
          default: begin
            cnt_ff <= '0;
            running_ff <= 1'b0;
          end
        endcase
      end else begin
        cnt_ff <= cnt_ff - CNT_W'(1);
      end
    end
  end

  // ************************************
  // output
  // ************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_ff <= 1'b1;
      tc_ff <= 1'b0;
    end else if (cmd.modeWr) begin
      out_ff <= (cmd.mode != SMIC_M0_TERM_INT);
      tc_ff <= 1'b0;
    end else begin
      tc_ff <= cntTick && cntEn && atOne;
      case (mode_ff)
        SMIC_M0_TERM_INT: begin
          if (cntTick && cntEn && atOne) out_ff <= 1'b1;
        end
        SMIC_M1_ONESHOT: begin
          if (cntTick && cntEn) out_ff <= atOne;
        end
        SMIC_M2_RATE: begin
          if (cntTick && cntEn) out_ff <= (cnt_ff != CNT_W'(2));
        end
        SMIC_M3_SQUARE: begin
          if (cmd.countWr) out_ff <= 1'b1;
          else if (cntTick && cntEn && cnt_ff <= CNT_W'(2)) out_ff <= ~out_ff;
        end
        SMIC_M4_SW_STROBE, SMIC_M5_HW_STROBE: begin
          if (cntTick) out_ff <= ~(cntEn && atOne);
        end
        default: out_ff <= 1'b1;
      endcase
    end
  end

  assign outPin = out_ff;
  assign terminalCount = tc_ff;

  // ************************************
  // checks
  // ************************************
  mode0_low_a: assert property (@(posedge clk) disable iff (!resetn)
    cmd.modeWr && cmd.mode == SMIC_M0_TERM_INT |=> !outPin)
    else $error("mode 0 write did not drop output");
  mode0_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M0_TERM_INT && outPin && !cmd.modeWr |=> outPin)
    else $error("mode 0 output fell after terminal count");
  mode0_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M0_TERM_INT && !gateIn && !cmd.modeWr && !cmd.countWr |=> $stable(cnt_ff))
    else $error("mode 0 counted with gate low");
  mode4_start_a: assert property (@(posedge clk) disable iff (!resetn)
    cmd.modeWr && cmd.mode == SMIC_M4_SW_STROBE |=> outPin)
    else $error("mode 4 did not start high");
  strobe_one_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M4_SW_STROBE && !cmd.modeWr && cntTick && cntEn && atOne |=> !outPin)
    else $error("mode 4 strobe missing");
  rate_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M2_RATE && !cmd.modeWr && !cmd.countWr && cntTick && cntEn &&
    cnt_ff == CNT_W'(2) |=> !outPin)
    else $error("mode 2 pulse missing");
  rate_reload_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M2_RATE && !cmd.modeWr && !cmd.countWr && cntTick && cntEn && atOne
    |=> cnt_ff == load_ff)
    else $error("mode 2 did not reload");
  tick_dec_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M4_SW_STROBE && !cmd.modeWr && !cmd.countWr && cntTick && cntEn &&
    cnt_ff > CNT_W'(1) |=> cnt_ff == $past(cnt_ff) - CNT_W'(1))
    else $error("count did not drop by one");

  // ************************************
  // checks for edge-started, square and strobe modes, and mode 0 terminal count
  // ************************************
  oneshot_low_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M1_ONESHOT && !cmd.modeWr && !cmd.countWr && cntTick && cntEn &&
    !atOne |=> !outPin)
    else $error("mode 1 output not low while counting");
  oneshot_high_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M1_ONESHOT && !cmd.modeWr && cntTick && cntEn && atOne |=> outPin)
    else $error("mode 1 output not high at terminal count");
  retrig_reload_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode_ff == SMIC_M1_ONESHOT || mode_ff == SMIC_M5_HW_STROBE) && running_ff && trig_ff &&
    gateRise && !cmd.modeWr && !cmd.countWr |=> cnt_ff == load_ff)
    else $error("gate edge did not restart the count");
  square_toggle_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M3_SQUARE && !cmd.modeWr && !cmd.countWr && cntTick && running_ff &&
    cnt_ff <= CNT_W'(2) |=> outPin != $past(outPin))
    else $error("mode 3 output did not flip at half count");
  square_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M3_SQUARE && !cmd.modeWr && !cmd.countWr && !cntTick
    |=> $stable(outPin))
    else $error("mode 3 output moved without a tick");
  hw_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M5_HW_STROBE && !trig_ff && !cmd.modeWr && !cmd.countWr
    |=> $stable(cnt_ff))
    else $error("mode 5 counted before a gate edge");
  strobe_return_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M4_SW_STROBE && !outPin && !running_ff && !cmd.modeWr && cntTick
    |=> outPin)
    else $error("mode 4 strobe longer than one tick");
  tc_out_a: assert property (@(posedge clk) disable iff (!resetn)
    mode_ff == SMIC_M0_TERM_INT && terminalCount |-> outPin)
    else $error("mode 0 output low at terminal count");
endmodule // smic_counter

// [rtl/smic_defines.svh]
`ifndef SMIC_DEFINES_SVH
`define SMIC_DEFINES_SVH
`define SMIC_CNT_W 16
`define SMIC_CNT_RST 16'h0000
`define SMIC_MODE_RST 3'h0
`endif

// [rtl/smic_pkg.sv]
package smic_pkg;
  typedef enum logic [2:0] {
    SMIC_M0_TERM_INT,
    SMIC_M1_ONESHOT,
    SMIC_M2_RATE,
    SMIC_M3_SQUARE,
    SMIC_M4_SW_STROBE,
    SMIC_M5_HW_STROBE
  } smic_mode_t;
  typedef struct packed {
    logic modeWr;
    smic_mode_t mode;
    logic countWr;
    logic [15:0] count;
  } smic_cmd_t;
endpackage

// [verification/smic_tick_src.sv]
`timescale 1ns/100ps
// ****************
// counting clock and gate source
// ****************
module smic_tick_src (
  input wire logic clk,
  input wire logic resetn,
  input wire logic gateReq,
  output logic cntTick,
  output logic gateIn
);
  logic [1:0] div_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end
  // one tick every fourth clk, back-to-back periods
  assign cntTick = (div_ff == 2'h3);
  assign gateIn = gateReq;
endmodule // smic_tick_src

// [verification/tb_six_mode_interval_counter.sv]
`timescale 1ns/100ps
module tb_six_mode_interval_counter;
  import smic_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic gateReq = 1'b0;
  logic cntTick, gateIn, outPin, terminalCount;
  smic_cmd_t cmd = '0;
  int errors = 0;
  int nCompared = 0;
  always #2 clk = ~clk;
  smic_tick_src src (.clk(clk), .resetn(resetn), .gateReq(gateReq), .cntTick(cntTick),
    .gateIn(gateIn));
  smic_counter DUT (.clk(clk), .resetn(resetn), .cntTick(cntTick), .gateIn(gateIn),
    .cmd(cmd), .outPin(outPin), .terminalCount(terminalCount));
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // mode is always written before the count
  task automatic setMode(input smic_mode_t m);
    cyc(1);
    cmd.mode = m;
    cmd.modeWr = 1'b1;
    cyc(1);
    cmd.modeWr = 1'b0;
  endtask
  task automatic load(input logic [15:0] c);
    cyc(1);
    cmd.count = c;
    cmd.countWr = 1'b1;
    cyc(1);
    cmd.countWr = 1'b0;
  endtask
  task automatic waitOut(input logic v);
    int i;
    i = 0;
    while (outPin !== v && i < 400) begin
      cyc(1);
      i++;
    end
    chk("outPin level", {15'h0000, outPin}, {15'h0000, v});
  endtask
  task automatic lowCount(input int win, input logic [15:0] exp);
    int n;
    waitOut(1'b0);
    n = 0;
    repeat (win) begin
      n += (outPin === 1'b0);
      cyc(1);
    end
    chk("low cycles", 16'(n), exp);
  endtask
  task automatic expOut(input logic v);
    chk("outPin", {15'h0000, outPin}, {15'h0000, v});
  endtask
  task report_and_stop;
    if (errors == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    errors++;
    report_and_stop;
  end
  // terminal count must show for exactly one clk cycle
  task automatic waitTc;
    int i;
    i = 0;
    while (terminalCount !== 1'b1 && i < 400) begin
      cyc(1);
      i++;
    end
    chk("terminalCount", {15'h0000, terminalCount}, 16'h0001);
    cyc(1);
    chk("terminalCount width", {15'h0000, terminalCount}, 16'h0000);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic scnMode0;
    setMode(SMIC_M0_TERM_INT);
    cyc(2);
    expOut(1'b0);
    load(16'h0003);
    cyc(40);
    expOut(1'b0);
    gateReq = 1'b1;
    cyc(8);
    expOut(1'b0);
    waitTc;
    expOut(1'b1);
    cyc(12);
    expOut(1'b1);
    gateReq = 1'b0;
    cyc(20);
    expOut(1'b1);
  endtask
  // third gate edge, arriving mid-shot, stretches the low phase by the reload
  task automatic scnMode1;
    setMode(SMIC_M1_ONESHOT);
    load(16'h0003);
    cyc(12);
    expOut(1'b1);
    gateReq = 1'b1;
    waitOut(1'b0);
    waitOut(1'b1);
    gateReq = 1'b0;
    cyc(2);
    gateReq = 1'b1;
    waitOut(1'b0);
    gateReq = 1'b0;
    cyc(2);
    gateReq = 1'b1;
    cyc(6);
    expOut(1'b0);
    cyc(4);
    expOut(1'b1);
  endtask
  task automatic scnMode2;
    setMode(SMIC_M2_RATE);
    load(16'h0003);
    lowCount(36, 16'h000c);
  endtask
  task automatic scnMode3;
    setMode(SMIC_M3_SQUARE);
    load(16'h0004);
    lowCount(32, 16'h0010);
  endtask
  task automatic scnMode4;
    gateReq = 1'b0;
    setMode(SMIC_M4_SW_STROBE);
    load(16'h0002);
    cyc(40);
    expOut(1'b1);
    gateReq = 1'b1;
    lowCount(20, 16'h0004);
  endtask
  task automatic scnMode5;
    setMode(SMIC_M5_HW_STROBE);
    load(16'h0002);
    cyc(40);
    expOut(1'b1);
    gateReq = 1'b0;
    cyc(4);
    gateReq = 1'b1;
    lowCount(20, 16'h0004);
  endtask
  initial begin
    cyc(20);
    resetn = 1'b1;
    expOut(1'b1);
    scnMode0;
    scnMode1;
    scnMode2;
    scnMode3;
    scnMode4;
    scnMode5;
    report_and_stop;
  end
endmodule // tb_six_mode_interval_counter
